// ---- include/ebt_pkg.sv ----
// Purpose: Shared constants for the external bus timing configuration.
// Assumes: Processor clock of 250 MHz; global register numbers are 5 bits.
// Notes:   Field positions follow the bus timing control word layout.

package ebt_pkg;

  // ---------------------------------------------------------------
  // Register access
  // ---------------------------------------------------------------
  localparam int          REG_NUM_W       = 5;
  localparam logic [4:0]  REG_BUS_TIMING  = 5'h14;  // Global reg twenty
  localparam logic [31:0] BUS_TIMING_RST  = 32'hFFFF_FFFF;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int PARITY_OFF_LSB   = 28;  // One bit per space, 28..31
  localparam int S3_ACCESS_LSB    = 24;  // 4 bits
  localparam int S3_HOLD_MSB_BIT  = 23;
  localparam int S2_ACCESS_LSB    = 20;  // 3 bits
  localparam int S1_ACCESS_LSB    = 18;  // 2 bits
  localparam int S0_ACCESS_LSB    = 16;  // 2 bits
  localparam int S1_HOLD_BIT      = 15;
  localparam int S2_SETUP_BIT     = 14;
  localparam int REFRESH_LSB      = 12;  // 2 bits
  localparam int PRECHARGE_LSB    = 10;  // 2 bits
  localparam int ROW_TO_COL_LSB   = 8;   // 2 bits
  localparam int PAGE_CODE_LSB    = 4;   // 3 bits
  localparam int S3_HOLD_LOW_LSB  = 2;   // 2 bits
  localparam int S2_HOLD_LSB      = 0;   // 2 bits

  // ---------------------------------------------------------------
  // Refresh timing and column address
  // ---------------------------------------------------------------
  localparam logic [1:0] REFRESH_OFF  = 2'h3;
  localparam logic [9:0] REFRESH_SLOW = 10'h200;  // 512 cycles
  localparam logic [3:0] COL_TOP_MAX  = 4'hF;     // A15 at page code 0
  localparam logic [1:0] BUS_W32      = 2'h0;
  localparam logic [1:0] BUS_W16      = 2'h1;
  localparam logic [1:0] COL_LOW_W32  = 2'h2;     // A2
  localparam logic [1:0] COL_LOW_W16  = 2'h1;     // A1
  localparam logic [1:0] COL_LOW_W8   = 2'h0;     // A0

  // Refresh interval in cycles: 512 >> code, zero when disabled
  function automatic logic [9:0] refresh_interval(input logic [1:0] code);
    if (code == REFRESH_OFF) begin
      return 10'h000;
    end
    return REFRESH_SLOW >> code;
  endfunction

  // Access-style codes count code plus one cycles
  function automatic logic [4:0] plus_one(input logic [3:0] code);
    return {1'b0, code} + 5'h01;
  endfunction

endpackage

// ---- include/ebt_refresh_if.sv ----
// Purpose: Carries the refresh interval code and the refresh request.
// Assumes: Both ends run on sys_clk.
// Notes:   Request is a one-cycle pulse.

`timescale 1ns/10ps

interface ebt_refresh_if;
  logic [1:0] interval_code;
  logic       refresh_req;

  modport ctrl  (output interval_code, input refresh_req);
  modport timer (input interval_code, output refresh_req);
endinterface

// ---- verilog/ebt_refresh_timer.sv ----
// Purpose: Paces column-before-row DRAM refresh requests.
// Assumes: Interval code comes from the bus timing control word.
// Notes:   A change between live codes restarts nothing; the count simply meets
//          the new limit, so the first gap after a change may differ.

`timescale 1ns/10ps

module ebt_refresh_timer
  import ebt_pkg::*;
#(
  parameter int CNT_W = 10
) (
  // Clock and reset
  input wire logic   sys_clk,
  input wire logic   rst_n,
  // Link to the configuration block
  ebt_refresh_if.timer rif
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             req;
  } ebt_timer_type;

  ebt_timer_type st;
  ebt_timer_type next_st;
  logic [CNT_W-1:0] limit;

  assign limit = CNT_W'(refresh_interval(rif.interval_code));

  // ---------------------------------------------------------------
  // Interval counter
  // ---------------------------------------------------------------
  // Pulse on the last cycle of each interval
  always_comb begin
    next_st = st;
    next_st.req = 1'b0;
    if (limit == '0) begin
      next_st.cnt = '0;  // see RULE_10
    end else if (st.cnt >= limit - CNT_W'(1)) begin
      next_st.cnt = '0;
      next_st.req = 1'b1;  // see RULE_10
    end else begin
      next_st.cnt = st.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rif.refresh_req = st.req;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Cycles since last request, for the spacing check; a code change
  // inside a gap makes that one gap irregular, so it is exempted
  logic [CNT_W-1:0] gap;
  logic             seen;
  logic [1:0]       code_prev;
  logic             moved;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap       <= '0;
      seen      <= 1'b0;
      code_prev <= 2'h3;
      moved     <= 1'b0;
    end else begin
      gap       <= st.req ? CNT_W'(1) : gap + CNT_W'(1);
      seen      <= seen | st.req;
      code_prev <= rif.interval_code;
      moved     <= st.req ? 1'b0
                   : (moved | (rif.interval_code != code_prev));
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_quiet;
    !rif.refresh_req [*8];
  endsequence

  a_refresh_off_quiet: assert property (  // see RULE_10
    rif.interval_code == REFRESH_OFF [*2] |-> !rif.refresh_req)
    else $error("refresh request while refresh disabled");
  a_refresh_gap_len: assert property (  // see RULE_10
    rif.refresh_req && seen && !moved && $stable(rif.interval_code)
      |-> gap == limit)
    else $error("refresh gap wrong");
  a_refresh_spaced: assert property (  // see RULE_10
    rif.refresh_req |=> s_quiet)
    else $error("refresh requests too close");

endmodule // ebt_refresh_timer

// ---- verilog/ebt_bus_timing.sv ----
// Purpose: Bus timing control word and per-access timing decode.
// Assumes: Register writes and access starts come from core logic
//          on sys_clk; space zero DRAM select comes from elsewhere.
// Notes:   The word is write-only; per-access decoded values are snapshots.
//
// Overview of operation
// RULE_01: Write-only word at global register twenty.
// RULE_02: Reset sets every bit to one.
// RULE_03: Bits 31..28 disable parity per space.
// RULE_04: Space three access is code plus one.
// RULE_05: Space two access is code plus one.
// RULE_06: Space one access is code plus one.
// RULE_07: Space zero access and column strobe window.
// RULE_08: Bit 15 adds space one hold cycle.
// RULE_09: Bit 14 adds space two setup cycle.
// RULE_10: Bits 13..12 choose refresh interval or off.
// RULE_11: DRAM: bits 11..10 give precharge plus one.
// RULE_12: Non-DRAM: bits 11..10 give space zero hold.
// RULE_13: Bits 9..8 give row-to-column delay plus one.
// RULE_14: Page code selects DRAM column address bits.
// RULE_15: Space three hold from bit 23, 3..2.
// RULE_16: Bits 1..0 give space two hold.
// RULE_17: Software programs the word after reset.
// RULE_18: Page code maps to column address ranges.
// RULE_19: New value applies from next access start.

`timescale 1ns/10ps

module ebt_bus_timing
  import ebt_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Global register write port
  input  wire logic        reg_wr,
  input  wire logic [4:0]  reg_num,
  input  wire logic [31:0] reg_wdata,
  // Access request from the bus sequencer
  input  wire logic        access_start,
  input  wire logic [1:0]  access_space,
  input  wire logic [1:0]  bus_width,
  input  wire logic        space_zero_is_dram,
  // Live configuration
  output logic [3:0]       parity_off,
  output logic             refresh_req,
  // Snapshot for the access just started
  output logic             acc_ready,
  output logic [4:0]       acc_cycles,
  output logic             acc_setup,
  output logic [2:0]       acc_hold,
  output logic             acc_parity_check,
  output logic [2:0]       acc_precharge,
  output logic [2:0]       acc_row_to_col,
  output logic [2:0]       acc_cas_first,
  output logic [2:0]       acc_cas_last,
  output logic             acc_cas_half,
  output logic [3:0]       col_top_bit,
  output logic [1:0]       col_low_bit
);

  typedef struct packed {
    logic [31:0] cfg;
    logic        ready;
    logic [4:0]  cycles;
    logic        setup;
    logic [2:0]  hold;
    logic        par_chk;
    logic [2:0]  precharge;
    logic [2:0]  row_to_col;
    logic [2:0]  cas_first;
    logic [2:0]  cas_last;
    logic        cas_half;
    logic [3:0]  col_top;
    logic [1:0]  col_low;
  } ebt_state_type;

  ebt_state_type st;
  ebt_state_type next_st;
  logic          cfg_wr;
  logic [1:0]    s0_code;
  logic [1:0]    pre_code;
  logic [2:0]    page_code;

  ebt_refresh_if rif ();

  // ---------------------------------------------------------------
  // Field views of the stored word
  // ---------------------------------------------------------------
  assign cfg_wr    = reg_wr && (reg_num == REG_BUS_TIMING);
  assign s0_code   = st.cfg[S0_ACCESS_LSB +: 2];
  assign pre_code  = st.cfg[PRECHARGE_LSB +: 2];
  assign page_code = st.cfg[PAGE_CODE_LSB +: 3];
  assign rif.interval_code = st.cfg[REFRESH_LSB +: 2];  // see RULE_10

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Snapshot uses the word as it stood before this cycle's write,
  // so an access never sees a value change mid-flight
  always_comb begin
    next_st = st;
    next_st.ready = 1'b0;
    if (cfg_wr) begin
      next_st.cfg = reg_wdata;  // see RULE_01
    end
    if (access_start) begin
      next_st.ready      = 1'b1;  // see RULE_19
      next_st.setup      = 1'b0;
      next_st.precharge  = 3'h0;
      next_st.row_to_col = 3'h0;
      next_st.cas_first  = 3'h0;
      next_st.cas_last   = 3'h0;
      next_st.cas_half   = 1'b0;
      next_st.par_chk    =
        !st.cfg[PARITY_OFF_LSB + int'(access_space)];  // see RULE_03
      unique case (access_space)
        2'h3: begin
          next_st.cycles =
            plus_one(st.cfg[S3_ACCESS_LSB +: 4]);  // see RULE_04
          next_st.hold = {st.cfg[S3_HOLD_MSB_BIT],
                          st.cfg[S3_HOLD_LOW_LSB +: 2]};  // see RULE_15
        end
        2'h2: begin
          next_st.cycles =
            plus_one({1'b0, st.cfg[S2_ACCESS_LSB +: 3]});  // see RULE_05
          next_st.setup = st.cfg[S2_SETUP_BIT];  // see RULE_09
          next_st.hold  =
            {1'b0, st.cfg[S2_HOLD_LSB +: 2]};  // see RULE_16
        end
        2'h1: begin
          next_st.cycles =
            plus_one({2'h0, st.cfg[S1_ACCESS_LSB +: 2]});  // see RULE_06
          next_st.hold = {2'h0, st.cfg[S1_HOLD_BIT]};  // see RULE_08
        end
        2'h0: begin
          next_st.cycles = plus_one({2'h0, s0_code});  // see RULE_07
          unique case (s0_code)
            2'h0: begin
              next_st.cas_first = 3'h1;  // see RULE_07
              next_st.cas_last  = 3'h1;
              next_st.cas_half  = 1'b1;
            end
            2'h1: begin
              next_st.cas_first = 3'h2;  // see RULE_07
              next_st.cas_last  = 3'h2;
            end
            2'h2: begin
              next_st.cas_first = 3'h2;  // see RULE_07
              next_st.cas_last  = 3'h3;
            end
            2'h3: begin
              next_st.cas_first = 3'h3;  // see RULE_07
              next_st.cas_last  = 3'h4;
            end
          endcase
          if (space_zero_is_dram) begin
            next_st.hold      = 3'h0;
            next_st.precharge =
              3'(plus_one({2'h0, pre_code}));  // see RULE_11
            next_st.row_to_col = 3'(plus_one(
              {2'h0, st.cfg[ROW_TO_COL_LSB +: 2]}));  // see RULE_13
          end else begin
            next_st.hold = {1'b0, pre_code};  // see RULE_12
          end
        end
      endcase
      // Column range only matters on DRAM, but is given always
      next_st.col_top = COL_TOP_MAX - {1'b0, page_code};  // see RULE_18
      unique case (bus_width)
        BUS_W32: next_st.col_low = COL_LOW_W32;  // see RULE_14
        BUS_W16: next_st.col_low = COL_LOW_W16;
        default: next_st.col_low = COL_LOW_W8;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Reset leaves the slowest, unchecked settings in place
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st     <= '0;
      st.cfg <= BUS_TIMING_RST;  // see RULE_02
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Refresh pacing
  // ---------------------------------------------------------------
  ebt_refresh_timer #(
    .CNT_W (10)
  ) u_refresh (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .rif     (rif.timer)
  );

  // ---------------------------------------------------------------
  // Outputs, all straight from state
  // ---------------------------------------------------------------
  assign parity_off       = st.cfg[PARITY_OFF_LSB +: 4];  // see RULE_03
  assign refresh_req      = rif.refresh_req;
  assign acc_ready        = st.ready;
  assign acc_cycles       = st.cycles;
  assign acc_setup        = st.setup;
  assign acc_hold         = st.hold;
  assign acc_parity_check = st.par_chk;
  assign acc_precharge    = st.precharge;
  assign acc_row_to_col   = st.row_to_col;
  assign acc_cas_first    = st.cas_first;
  assign acc_cas_last     = st.cas_last;
  assign acc_cas_half     = st.cas_half;
  assign col_top_bit      = st.col_top;
  assign col_low_bit      = st.col_low;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Set once software has written the word
  logic written;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      written <= 1'b0;
    end else begin
      written <= written | cfg_wr;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Access start with the word held steady across it
  sequence s_start(logic [1:0] sp);
    access_start && access_space == sp && !cfg_wr;
  endsequence

  a_reset_all_ones: assert property (  // see RULE_02
    !written |-> st.cfg == BUS_TIMING_RST && parity_off == 4'hF)
    else $error("word not all ones before first write");
  a_write_word_taken: assert property (  // see RULE_01
    cfg_wr |=> st.cfg == $past(reg_wdata))
    else $error("write to register twenty lost");
  a_other_reg_ignored: assert property (  // see RULE_01
    reg_wr && reg_num != REG_BUS_TIMING |=> $stable(st.cfg))
    else $error("write to other register changed word");
  a_parity_snap: assert property (  // see RULE_03
    access_start && !cfg_wr |=>
      acc_parity_check != st.cfg[PARITY_OFF_LSB + int'($past(access_space))])
    else $error("parity check enable wrong");
  a_s3_access: assert property (  // see RULE_04
    s_start(2'h3) |=> acc_cycles == {1'b0, st.cfg[27:24]} + 5'h01)
    else $error("space three access time wrong");
  a_s3_hold: assert property (  // see RULE_15
    s_start(2'h3) |=> acc_hold == {st.cfg[23], st.cfg[3:2]})
    else $error("space three hold wrong");
  a_s2_access: assert property (  // see RULE_05
    s_start(2'h2) |=> acc_cycles == {2'h0, st.cfg[22:20]} + 5'h01
      && acc_hold == {1'b0, st.cfg[1:0]})  // see RULE_16
    else $error("space two access or hold wrong");
  a_s2_setup: assert property (  // see RULE_09
    s_start(2'h2) |=> acc_setup == st.cfg[14])
    else $error("space two setup wrong");
  a_s1_timing: assert property (  // see RULE_06
    s_start(2'h1) |=> acc_cycles == {3'h0, st.cfg[19:18]} + 5'h01
      && acc_hold == {2'h0, st.cfg[15]} && !acc_setup)  // see RULE_08
    else $error("space one timing wrong");
  a_s0_cas_window: assert property (  // see RULE_07
    s_start(2'h0) |=> acc_cas_last == acc_cycles[2:0]
      && acc_cas_first == acc_cycles[2:0] - {2'h0, acc_cycles > 5'h02}
      && acc_cas_half == (acc_cycles == 5'h01))
    else $error("column strobe window wrong");
  a_s0_dram: assert property (  // see RULE_11
    s_start(2'h0) && space_zero_is_dram |=> acc_hold == 3'h0
      && acc_precharge == {1'b0, st.cfg[11:10]} + 3'h1
      && acc_row_to_col == {1'b0, st.cfg[9:8]} + 3'h1)  // see RULE_13
    else $error("space zero DRAM timing wrong");
  a_s0_static: assert property (  // see RULE_12
    s_start(2'h0) && !space_zero_is_dram |=>
      acc_hold == {1'b0, st.cfg[11:10]} && acc_precharge == 3'h0)
    else $error("space zero hold wrong");
  a_col_range: assert property (  // see RULE_18
    access_start && !cfg_wr && bus_width == BUS_W32 |=>
      col_top_bit + {1'b0, st.cfg[6:4]} == 4'hF && col_low_bit == 2'h2)
    else $error("column range wrong");
  a_snapshot_held: assert property (  // see RULE_19
    !access_start |=> $stable(acc_cycles) && $stable(acc_hold)
      && !acc_ready)
    else $error("snapshot changed without access start");
  a_refresh_code: assert property (  // see RULE_10
    st.cfg[13:12] == 2'h3 [*2] |-> !refresh_req)
    else $error("refresh while disabled");

endmodule // ebt_bus_timing

// ---- verif/ebt_mem_model.sv ----
// Purpose: Behavioural far-side memory that times each started access.
// Assumes: Snapshot outputs of the timing block drive it directly.
// Notes:   Busy spans setup, access and hold cycles of one access.

`timescale 1ns/10ps

module ebt_mem_model
  import ebt_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Snapshot of the access just started
  input  wire logic       acc_ready,
  input  wire logic [4:0] acc_cycles,
  input  wire logic       acc_setup,
  input  wire logic [2:0] acc_hold,
  // Memory still occupied by the access
  output logic            mem_busy
);
  // ---------------------------------------------------------------
  // Access occupancy
  // ---------------------------------------------------------------
  logic [5:0] busy_cnt;

  // Timing is frozen at start, later writes cannot stretch it
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt <= 6'h00;
    end else if (acc_ready === 1'b1) begin
      busy_cnt <= {5'h00, acc_setup} + {1'b0, acc_cycles}
                  + {3'h0, acc_hold};
    end else if (busy_cnt != 6'h00) begin
      busy_cnt <= busy_cnt - 6'h01;
    end
  end

  assign mem_busy = (busy_cnt != 6'h00);
endmodule  // ebt_mem_model

// ---- verif/testbench.sv ----
// Purpose: Self-checking bench for the bus timing control word.
// Assumes: 250 MHz clock; inputs driven by non-blocking assignment.
// Notes:   Expected values are decoded here from the written word.

`timescale 1ns/10ps

module testbench;
  import ebt_pkg::*;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        reg_wr = 1'b0;
  logic [4:0]  reg_num = 5'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        access_start = 1'b0;
  logic [1:0]  access_space = 2'h0;
  logic [1:0]  bus_width = 2'h0;
  logic        space_zero_is_dram = 1'b0;
  logic [3:0]  parity_off;
  logic        refresh_req, acc_ready, acc_setup, acc_parity_check;
  logic [4:0]  acc_cycles;
  logic [2:0]  acc_hold, acc_precharge, acc_row_to_col;
  logic [2:0]  acc_cas_first, acc_cas_last;
  logic        acc_cas_half, mem_busy;
  logic [3:0]  col_top_bit;
  logic [1:0]  col_low_bit;
  int          err_count = 0;
  int          n_tests = 0;
  logic [31:0] words [4] = '{32'h0000_0000, 32'hA5A5_5A5A,
                             32'h5A96_C3A1, 32'h3C3F_9F9C};

  // Free-running 4 ns clock
  always #2 sys_clk = ~sys_clk;

  ebt_bus_timing i_ebt_bus_timing (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_num(reg_num), .reg_wdata(reg_wdata),
    .access_start(access_start), .access_space(access_space),
    .bus_width(bus_width), .space_zero_is_dram(space_zero_is_dram),
    .parity_off(parity_off), .refresh_req(refresh_req),
    .acc_ready(acc_ready), .acc_cycles(acc_cycles),
    .acc_setup(acc_setup), .acc_hold(acc_hold),
    .acc_parity_check(acc_parity_check),
    .acc_precharge(acc_precharge), .acc_row_to_col(acc_row_to_col),
    .acc_cas_first(acc_cas_first), .acc_cas_last(acc_cas_last),
    .acc_cas_half(acc_cas_half), .col_top_bit(col_top_bit),
    .col_low_bit(col_low_bit));
  ebt_mem_model i_ebt_mem_model (.sys_clk(sys_clk), .rst_n(rst_n),
    .acc_ready(acc_ready), .acc_cycles(acc_cycles),
    .acc_setup(acc_setup), .acc_hold(acc_hold), .mem_busy(mem_busy));

  // ---------------------------------------------------------------
  // Reporting
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Refresh gaps are a separate kind of result
  task automatic chk_gap(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      err_count++;
      $display("ERROR t=%0t gap=%h exp=%h", $time, got, exp);
    end
  endtask

  // ---------------------------------------------------------------
  // Drivers
  // ---------------------------------------------------------------
  task automatic write_word(input logic [4:0] num, input logic [31:0] w);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_num <= num;
    reg_wdata <= w;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // One access, judged against the decode of word w
  task automatic check_access(input logic [31:0] w, input logic [1:0] s,
                              input logic d, input logic [1:0] bw);
    logic [4:0] ec;
    logic [2:0] eh;
    logic [1:0] c0;
    int         i;
    int         et;
    c0 = w[17:16];
    case (s)
      2'h3: ec = {1'b0, w[27:24]} + 5'h01;
      2'h2: ec = {2'h0, w[22:20]} + 5'h01;
      2'h1: ec = {3'h0, w[19:18]} + 5'h01;
      default: ec = {3'h0, c0} + 5'h01;
    endcase
    case (s)
      2'h3: eh = {w[23], w[3:2]};
      2'h2: eh = {1'b0, w[1:0]};
      2'h1: eh = {2'h0, w[15]};
      default: eh = d ? 3'h0 : {1'b0, w[11:10]};
    endcase
    // Memory stays busy for setup, access and hold cycles
    et = int'(ec) + int'(eh) + int'((s == 2'h2) & w[14]);
    @(posedge sys_clk);
    access_start <= 1'b1;
    access_space <= s;
    bus_width <= bw;
    space_zero_is_dram <= d;
    @(posedge sys_clk);
    access_start <= 1'b0;
    #1;
    chk(32'(acc_ready), 32'h1);
    chk(32'(acc_cycles), 32'(ec));
    chk(32'(acc_hold), 32'(eh));
    chk(32'(acc_setup), 32'((s == 2'h2) & w[14]));
    chk(32'(acc_parity_check), 32'(!w[28 + s]));
    chk(32'(acc_precharge), (s == 0 && d) ? w[11:10] + 1 : 0);
    chk(32'(acc_row_to_col), (s == 0 && d) ? w[9:8] + 1 : 0);
    chk(32'(acc_cas_first), s != 0 ? 0 : c0 == 3 ? 3 : c0 == 0 ? 1 : 2);
    chk(32'(acc_cas_last), s != 0 ? 0 : c0 + 1);
    chk(32'(acc_cas_half), 32'(s == 0 && c0 == 0));
    chk(32'(col_top_bit), 32'(4'hF - {1'b0, w[6:4]}));
    chk(32'(col_low_bit), bw == 0 ? 2 : bw == 1 ? 1 : 0);
    @(posedge sys_clk);
    #1;
    chk(32'(acc_ready), 32'h0);
    for (i = 0; i < 40 && mem_busy === 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk(32'(i), 32'(et));
    if (mem_busy !== 1'b0) begin
      err_count++;
      close_out();
    end
  endtask

  // Cycles until the next refresh pulse, bounded
  task automatic next_pulse(output int n);
    for (n = 1; n < 700; n++) begin
      @(posedge sys_clk);
      #1;
      if (refresh_req === 1'b1) break;
    end
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic scen_reset();
    int n;
    chk(32'(parity_off), 32'hF);
    check_access(BUS_TIMING_RST, 2'h3, 1'b0, 2'h0);
    next_pulse(n);
    chk_gap(n, 700);
  endtask

  task automatic scen_unmapped();
    write_word(5'h13, 32'h0000_0000);
    chk(32'(parity_off), 32'hF);
    write_word(REG_BUS_TIMING, 32'h5FFF_FFFF);
    chk(32'(parity_off), 32'h5);
  endtask

  // Every word against every space and DRAM choice, bus width set to space plus DRAM
  task automatic scen_table();
    for (int k = 0; k < 4; k++) begin
      write_word(REG_BUS_TIMING, words[k]);
      for (int s = 0; s < 4; s++) begin
        for (int d = 0; d < 2; d++) begin
          check_access(words[k], 2'(s), 1'(d), 2'(s + d));
        end
      end
    end
  endtask

  // Write landing with a start: that start keeps the old word
  task automatic scen_same_cycle();
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_num <= REG_BUS_TIMING;
    reg_wdata <= words[1];
    access_start <= 1'b1;
    access_space <= 2'h3;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    access_start <= 1'b0;
    #1;
    chk(32'(acc_cycles), 32'(words[3][27:24]) + 1);
    check_access(words[1], 2'h3, 1'b0, 2'h1);
  endtask

  task automatic scen_refresh(input logic [1:0] code);
    int n;
    write_word(REG_BUS_TIMING, 32'hFFFF_CFFF | ({30'h0, code} << 12));
    next_pulse(n);
    next_pulse(n);
    chk_gap(n, 512 >> code);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    scen_reset();
    scen_unmapped();
    scen_table();
    scen_same_cycle();
    for (int c = 0; c < 3; c++) begin
      scen_refresh(2'(c));
    end
    close_out();
  end
endmodule  // testbench
